// File: verilog/msir_params.svh
// Purpose: constants for the motion sensor interrupt router
// Assumes: 8-bit register port, byte addresses as printed
// Notes: definitions only
`ifndef MSIR_PARAMS_SVH
`define MSIR_PARAMS_SVH
`define MSIR_ADDR_SOURCE 8'h0c
`define MSIR_ADDR_ENABLE 8'h2d
`define MSIR_ADDR_ROUTING 8'h2e
`define MSIR_BIT_SLEEP_WAKE 7
`define MSIR_BIT_TRANSIENT 5
`define MSIR_BIT_ORIENTATION 4
`define MSIR_BIT_PULSE 3
`define MSIR_BIT_FALL_MOTION 2
`define MSIR_BIT_SAMPLE_READY 0
`define MSIR_SRC_MASK 8'hbd
`define MSIR_RESET_ENABLE 8'h00
`define MSIR_RESET_ROUTING 8'h00
`define MSIR_RESET_POLARITY 1'b0
`endif

// File: verilog/msir_pkg.sv
// Purpose: types for the motion sensor interrupt router
// Assumes: nothing
// Notes: constants live in msir_params.svh
package msir_pkg;
    typedef logic [7:0] msir_byte_t;
endpackage : msir_pkg

// File: verilog/msir_pin_drv.sv
// Purpose: one interrupt pin: combine routed sources, apply polarity
// Assumes: flags and settings synchronous to core_clk
// Notes: output comes from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module msir_pin_drv
    import msir_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // selection
    input wire logic [7:0] gated_flags,
    input wire logic [7:0] select_mask,
    input wire logic irq_polarity,
    // pin
    output logic pin_level
);
    typedef struct packed {
        logic pin;
    } msir_pin_state_t;
    msir_pin_state_t st_q;
    msir_pin_state_t st_d;
    logic active;
    always_comb begin
        active = |(gated_flags & select_mask);
        st_d.pin = irq_polarity ? active : ~active;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q.pin <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end
    assign pin_level = st_q.pin;
    // first edge after a release still shows the reset level, so skip it
    a_pin_follows: assert property (@(posedge core_clk) disable iff (!resetn)
        $past(resetn) |-> pin_level == ($past(irq_polarity) ? $past(active) : !$past(active)))
        else $error("pin level does not follow routed flags");
endmodule : msir_pin_drv
`default_nettype wire

// File: verilog/msir_router.sv
// Purpose: interrupt enable, routing and pin drive of a motion sensor
// Assumes: simple synchronous 8-bit register port, one write per cycle
// Notes: detection blocks are outside; their flags arrive as inputs
`timescale 1ns/1ps
`default_nettype none
`include "msir_params.svh"
// What this block does
// - disabled source never reaches a pin
// - enable bits sit at fixed positions
// - enable bits reset to zero
// - routing zero picks second pin, one first
// - routing bits mirror enable positions
// - routing bits reset to zero
// - pin ORs all routed enabled sources
// - polarity bit zero means active low
module msir_router
    import msir_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // polarity setting held elsewhere
    input wire logic irq_polarity,
    // event flags from detection blocks, at source bit positions
    input wire logic [7:0] event_flags,
    // interrupt pins
    output logic irq_pin_first,
    output logic irq_pin_second
);
    typedef struct packed {
        msir_byte_t enable;
        msir_byte_t routing;
        msir_byte_t rdata;
    } msir_state_t;
    msir_state_t st_q;
    msir_state_t st_d;
    msir_byte_t gated;
    msir_byte_t source;
    msir_byte_t en_map;
    msir_byte_t route_map;

    // named views of the two registers, one bit per source
    logic en_sleep_wake;
    logic en_transient;
    logic en_orientation;
    logic en_pulse;
    logic en_fall_motion;
    logic en_sample_ready;
    logic route_sleep_wake;
    logic route_transient;
    logic route_orientation;
    logic route_pulse;
    logic route_fall_motion;
    logic route_sample_ready;
    assign en_sleep_wake = st_q.enable[`MSIR_BIT_SLEEP_WAKE];
    assign en_transient = st_q.enable[`MSIR_BIT_TRANSIENT];
    assign en_orientation = st_q.enable[`MSIR_BIT_ORIENTATION];
    assign en_pulse = st_q.enable[`MSIR_BIT_PULSE];
    assign en_fall_motion = st_q.enable[`MSIR_BIT_FALL_MOTION];
    assign en_sample_ready = st_q.enable[`MSIR_BIT_SAMPLE_READY];
    assign route_sleep_wake = st_q.routing[`MSIR_BIT_SLEEP_WAKE];
    assign route_transient = st_q.routing[`MSIR_BIT_TRANSIENT];
    assign route_orientation = st_q.routing[`MSIR_BIT_ORIENTATION];
    assign route_pulse = st_q.routing[`MSIR_BIT_PULSE];
    assign route_fall_motion = st_q.routing[`MSIR_BIT_FALL_MOTION];
    assign route_sample_ready = st_q.routing[`MSIR_BIT_SAMPLE_READY];

    // rebuilt from the named bits so reserved positions can never gate or steer
    always_comb begin
        en_map = 8'h00;
        en_map[`MSIR_BIT_SLEEP_WAKE] = en_sleep_wake;
        en_map[`MSIR_BIT_TRANSIENT] = en_transient;
        en_map[`MSIR_BIT_ORIENTATION] = en_orientation;
        en_map[`MSIR_BIT_PULSE] = en_pulse;
        en_map[`MSIR_BIT_FALL_MOTION] = en_fall_motion;
        en_map[`MSIR_BIT_SAMPLE_READY] = en_sample_ready;
        route_map = 8'h00;
        route_map[`MSIR_BIT_SLEEP_WAKE] = route_sleep_wake;
        route_map[`MSIR_BIT_TRANSIENT] = route_transient;
        route_map[`MSIR_BIT_ORIENTATION] = route_orientation;
        route_map[`MSIR_BIT_PULSE] = route_pulse;
        route_map[`MSIR_BIT_FALL_MOTION] = route_fall_motion;
        route_map[`MSIR_BIT_SAMPLE_READY] = route_sample_ready;
    end

    // mask and bit positions live apart in the header; refuse a mismatch
    localparam msir_byte_t SRC_POS_MASK = msir_byte_t'((1 << `MSIR_BIT_SLEEP_WAKE)
        | (1 << `MSIR_BIT_TRANSIENT) | (1 << `MSIR_BIT_ORIENTATION)
        | (1 << `MSIR_BIT_PULSE) | (1 << `MSIR_BIT_FALL_MOTION)
        | (1 << `MSIR_BIT_SAMPLE_READY));
    if (SRC_POS_MASK != `MSIR_SRC_MASK) begin : g_bad_mask
        $error("source mask disagrees with source bit positions");
    end

    always_comb begin
        st_d = st_q;
        source = event_flags & `MSIR_SRC_MASK;
        gated = source & en_map;
        if (reg_wr) begin
            case (reg_addr)
                `MSIR_ADDR_ENABLE: begin
                    st_d.enable = reg_wdata & `MSIR_SRC_MASK;
                end
                `MSIR_ADDR_ROUTING: begin
                    st_d.routing = reg_wdata & `MSIR_SRC_MASK;
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `MSIR_ADDR_SOURCE: st_d.rdata = gated;
                `MSIR_ADDR_ENABLE: st_d.rdata = st_q.enable;
                `MSIR_ADDR_ROUTING: st_d.rdata = st_q.routing;
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q.enable <= `MSIR_RESET_ENABLE;
            st_q.routing <= `MSIR_RESET_ROUTING;
            st_q.rdata <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end
    assign reg_rdata = st_q.rdata;

    // same driver for both pins keeps their timing identical
    msir_pin_drv u_pin_first (
        .core_clk(core_clk),
        .resetn(resetn),
        .gated_flags(gated),
        .select_mask(route_map),
        .irq_polarity(irq_polarity),
        .pin_level(irq_pin_first)
    );
    msir_pin_drv u_pin_second (
        .core_clk(core_clk),
        .resetn(resetn),
        .gated_flags(gated),
        .select_mask(~route_map),
        .irq_polarity(irq_polarity),
        .pin_level(irq_pin_second)
    );

    // pins register the polarity of the cycle before, hence $past on it
    a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q.enable == 8'h00) |=> (irq_pin_first == !$past(irq_polarity)
        && irq_pin_second == !$past(irq_polarity)))
        else $error("disabled sources drove a pin");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        ((st_q.enable & 8'h42) == 8'h00) && ((st_q.routing & 8'h42) == 8'h00))
        else $error("reserved bit set");

    a_enable_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `MSIR_ADDR_ENABLE) |=> st_q.enable == ($past(reg_wdata) & 8'hbd))
        else $error("enable write lost");

    a_route_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr == `MSIR_ADDR_ROUTING) |=> st_q.routing == ($past(reg_wdata) & 8'hbd))
        else $error("routing write lost");

    a_route_exclusive: assert property (@(posedge core_clk) disable iff (!resetn)
        (irq_polarity && $stable(irq_polarity) && (gated & st_q.routing) == 8'h00
        && gated != 8'h00) |=> (!irq_pin_first && irq_pin_second))
        else $error("routing to wrong pin");

    a_source_read: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `MSIR_ADDR_SOURCE) |=> reg_rdata == $past(gated))
        else $error("source read wrong");

    a_low_active: assert property (@(posedge core_clk) disable iff (!resetn)
        (!irq_polarity && (gated & st_q.routing) != 8'h00) |=> !irq_pin_first)
        else $error("active low pin not low");

    a_pin_release: assert property (@(posedge core_clk) disable iff (!resetn)
        (irq_polarity && gated == 8'h00) |=> (!irq_pin_first && !irq_pin_second))
        else $error("pin not released");

    a_reset_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(resetn) |-> (st_q.enable == `MSIR_RESET_ENABLE
        && st_q.routing == `MSIR_RESET_ROUTING))
        else $error("settings not cleared by reset");

    a_enable_read: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `MSIR_ADDR_ENABLE) |=> reg_rdata == $past(st_q.enable))
        else $error("enable read wrong");

    a_route_read: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_rd && reg_addr == `MSIR_ADDR_ROUTING) |=> reg_rdata == $past(st_q.routing))
        else $error("routing read wrong");

    a_other_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_wr && reg_addr != `MSIR_ADDR_ENABLE && reg_addr != `MSIR_ADDR_ROUTING)
        |=> ($stable(st_q.enable) && $stable(st_q.routing)))
        else $error("foreign write changed settings");

    a_first_high: assert property (@(posedge core_clk) disable iff (!resetn)
        (irq_polarity && (gated & route_map) != 8'h00) |=> irq_pin_first)
        else $error("first pin not asserted");

    a_second_high: assert property (@(posedge core_clk) disable iff (!resetn)
        (irq_polarity && (gated & ~route_map) != 8'h00) |=> irq_pin_second)
        else $error("second pin not asserted");

    a_second_low: assert property (@(posedge core_clk) disable iff (!resetn)
        (!irq_polarity && (gated & ~route_map) != 8'h00) |=> !irq_pin_second)
        else $error("active low second pin not low");

    a_idle_high_level: assert property (@(posedge core_clk) disable iff (!resetn)
        (!irq_polarity && gated == 8'h00) |=> (irq_pin_first && irq_pin_second))
        else $error("active low pin not idle high");

    a_rdata_stands: assert property (@(posedge core_clk) disable iff (!resetn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule : msir_router
`default_nettype wire

// File: tb/msir_host_model.sv
// Purpose: host side watching both interrupt pins
// Assumes: pins are registered levels in the core_clk domain
// Notes: only decodes polarity; the bench does the source read
`timescale 1ns/1ps
`default_nettype none
module msir_host_model (
    // pins and polarity
    input wire logic irq_pin_first,
    input wire logic irq_pin_second,
    input wire logic irq_polarity,
    // decoded state
    output logic host_irq_seen
);
    // a pin is active when it equals the polarity bit
    assign host_irq_seen = (irq_pin_first ~^ irq_polarity) | (irq_pin_second ~^ irq_polarity);
endmodule : msir_host_model
`default_nettype wire

// File: tb/msir_router_tb.sv
// Purpose: self-checking bench for msir_router
// Assumes: strobe register port, one clock
// Notes: walks each source both ways, then random settings
`timescale 1ns/1ps
`default_nettype none
module msir_router_tb;
    import msir_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_polarity = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, event_flags = 8'h00, reg_rdata;
    logic irq_pin_first, irq_pin_second, host_irq_seen;
    int miscompares = 0, comparisons = 0, cycles = 0, en_m = 0, rt_m = 0;
    integer seed = 32'ha27e7ae6;
    msir_router DUT (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq_polarity(irq_polarity), .event_flags(event_flags),
        .irq_pin_first(irq_pin_first), .irq_pin_second(irq_pin_second));
    msir_host_model host (.irq_pin_first(irq_pin_first), .irq_pin_second(irq_pin_second),
        .irq_polarity(irq_polarity), .host_irq_seen(host_irq_seen));
    always #10 core_clk = ~core_clk;
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] got, input int exp, input string what);
        comparisons++;
        if (got !== 8'(exp)) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, 8'(exp));
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a == 8'h2d)
            en_m = d & 8'hbd;
        if (a == 8'h2e)
            rt_m = d & 8'hbd;
    endtask : wr
    task automatic rd(input logic [7:0] a, input int exp, input string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp, what);
    endtask : rd
    task automatic pins();
        int act;
        repeat (3) @(posedge core_clk);
        #1;
        act = event_flags & en_m;
        check({7'h00, irq_pin_first}, int'((act & rt_m) != 0) == int'(irq_polarity), "pin1");
        check({7'h00, irq_pin_second}, int'((act & ~rt_m) != 0) == int'(irq_polarity), "pin2");
        if (host_irq_seen === 1'b1)
            rd(8'h0c, act, "source");
        rd(8'h2d, en_m, "enable");
        rd(8'h2e, rt_m, "routing");
    endtask : pins
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        wr(8'h2f, 8'hff);
        pins();
        rd(8'h10, 0, "unmapped");
        for (int i = 0; i < 16; i++) begin
            wr(8'h2d, 8'hff);
            wr(8'h2e, (i % 2) ? 8'hff : 8'h00);
            event_flags <= 8'(1 << (i / 2));
            pins();
        end
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        en_m = 0;
        rt_m = 0;
        pins();
        for (int i = 0; i < 40; i++) begin
            wr(8'h2d, 8'($random(seed)));
            wr(8'h2e, 8'($random(seed)));
            event_flags <= 8'($random(seed));
            irq_polarity <= 1'($random(seed));
            pins();
        end
        @(posedge core_clk);
        event_flags <= 8'h00;
        pins();
        complete_run();
    end
endmodule : msir_router_tb
`default_nettype wire
